// *** verilog/adc_serial_pkg.sv ***
// Shared constants and types of the converter serial port
package adc_serial_pkg;
  // ----------------------------------------------------------------
  // Frame and conversion sequencing
  // ----------------------------------------------------------------
  localparam int RESULT_BITS = 10;
  localparam int CMD_BITS = 8;
  localparam int CHAN_BITS = 3;
  localparam logic [4:0] FALLS_PER_CONV = 5'h10;
  localparam logic [4:0] TRACK_FALLS = 5'h03;
  localparam logic [4:0] HOLD_FALL = 5'h04;
  localparam logic [4:0] RESULT_FIRST_FALL = 5'h05;
  localparam logic [4:0] RESULT_LAST_FALL = 5'h0E;
  localparam logic [3:0] CMD_LAST_RISE = 4'h7;
  localparam logic [3:0] CONV_LAST_RISE = 4'hF;
  localparam logic [3:0] CMD_RISES = 4'h8;
  // ----------------------------------------------------------------
  // Channel select control word layout
  // ----------------------------------------------------------------
  localparam int CHAN_CODE_BIT2 = 5;
  localparam int CHAN_CODE_BIT0 = 3;
  localparam logic [2:0] CHAN_RESET = 3'h0;
  localparam logic [CMD_BITS-1:0] CMD_RESET = 8'h00;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    PH_OFF   = 5'b00001,
    PH_ARMED = 5'b00010,
    PH_TRACK = 5'b00100,
    PH_HOLD  = 5'b01000,
    PH_GAP   = 5'b10000
  } conv_phase_t;

  typedef struct packed {
    logic [CHAN_BITS-1:0] channel;
    logic [RESULT_BITS-1:0] code;
  } conv_result_t;

  localparam int RESULT_W = CHAN_BITS + RESULT_BITS;

  function automatic logic [CHAN_BITS-1:0] chan_field(input logic [CMD_BITS-1:0] word);
    chan_field = word[CHAN_CODE_BIT2:CHAN_CODE_BIT0];
  endfunction
endpackage

// *** verilog/result_buffer.sv ***
// Two-entry valid/ready buffer for conversion results
`timescale 1ns/100ps
module result_buffer #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 2
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign o_in_ready = (count != (PW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || i_flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// *** verilog/adc_serial_port.sv ***
// Serial frame and conversion sequencing of an eight-channel converter
`timescale 1ns/100ps
module adc_serial_port
  import adc_serial_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_frame_sel_n,
  input wire logic i_shift_clk,
  input wire logic i_cmd_in,
  output logic o_data_out,
  output logic o_data_out_oe,
  output logic o_powered,
  output logic o_tracking,
  output logic o_holding,
  output logic [CHAN_BITS-1:0] o_track_channel,
  output logic o_conv_start,
  input wire logic i_result_valid,
  input wire logic [RESULT_BITS-1:0] i_result,
  output logic o_result_ready
);
  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic sel_s1;
  logic sel_s2;
  logic sel_s3;
  logic clk_s1;
  logic clk_s2;
  logic clk_s3;
  logic din_s1;
  logic din_s2;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      sel_s3 <= 1'b1;
    end else begin
      sel_s1 <= i_frame_sel_n;
      sel_s2 <= sel_s1;
      sel_s3 <= sel_s2;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
    end else begin
      clk_s1 <= i_shift_clk;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end else begin
      din_s1 <= i_cmd_in;
      din_s2 <= din_s1;
    end
  end

  logic sel_active;
  logic sel_fall;
  logic clk_rise;
  logic clk_fall;
  logic first_fall;
  logic fall_ev;

  assign sel_active = ~sel_s2;
  assign sel_fall = sel_s3 & ~sel_s2;
  // Edges only count inside a frame; the select fall edge itself is handled apart
  assign clk_rise = sel_active & ~sel_fall & clk_s2 & ~clk_s3;
  assign clk_fall = sel_active & ~sel_fall & ~clk_s2 & clk_s3;
  assign first_fall = sel_fall & ~clk_s2;
  assign fall_ev = clk_fall | first_fall;

  // ----------------------------------------------------------------
  // Conversion phase and edge counters
  // ----------------------------------------------------------------
  conv_phase_t phase;
  conv_phase_t next_phase;
  logic [4:0] fall_idx;
  logic [4:0] next_fall_idx;
  logic [3:0] rise_idx;
  logic started;

  assign started = (phase == PH_TRACK) || (phase == PH_HOLD) || (phase == PH_GAP);

  always_comb begin
    if (first_fall || phase == PH_ARMED || phase == PH_GAP) begin
      next_fall_idx = 5'h01;
    end else begin
      next_fall_idx = fall_idx + 5'h01;
    end
  end

  always_comb begin
    next_phase = phase;
    case (phase)
      PH_OFF: begin
        if (sel_fall) begin
          next_phase = clk_s2 ? PH_ARMED : PH_TRACK;
        end
      end
      PH_ARMED: begin
        if (clk_fall) begin
          next_phase = PH_TRACK;
        end
      end
      PH_TRACK: begin
        if (clk_fall && next_fall_idx == HOLD_FALL) begin
          next_phase = PH_HOLD;
        end
      end
      PH_HOLD: begin
        if (clk_fall && next_fall_idx == FALLS_PER_CONV) begin
          next_phase = PH_GAP;
        end
      end
      PH_GAP: begin
        if (clk_fall) begin
          next_phase = PH_TRACK;
        end
      end
      default: next_phase = PH_OFF;
    endcase
    if (!sel_active) begin
      next_phase = PH_OFF;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      phase <= PH_OFF;
    end else begin
      phase <= next_phase;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !sel_active) begin
      fall_idx <= 5'h00;
    end else if (fall_ev) begin
      fall_idx <= next_fall_idx;
    end
  end

  // Rising edges are counted modulo one conversion
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !sel_active) begin
      rise_idx <= 4'h0;
    end else if (clk_rise && started) begin
      rise_idx <= rise_idx + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Channel select control word
  // ----------------------------------------------------------------
  logic [CMD_BITS-1:0] cmd_shift;
  logic [CMD_BITS-1:0] next_cmd;
  logic [CHAN_BITS-1:0] chan_pending;
  logic [CHAN_BITS-1:0] chan_active;

  assign next_cmd = {cmd_shift[CMD_BITS-2:0], din_s2};

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cmd_shift <= CMD_RESET;
    end else if (clk_rise && started && rise_idx < CMD_RISES) begin
      cmd_shift <= next_cmd;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      chan_pending <= CHAN_RESET;
    end else if (clk_rise && started && rise_idx == CMD_LAST_RISE) begin
      chan_pending <= chan_field(next_cmd);
    end
  end

  // Committed only when a conversion completes its sixteenth rise
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      chan_active <= CHAN_RESET;
    end else if (clk_rise && started && rise_idx == CONV_LAST_RISE) begin
      chan_active <= chan_pending;
    end
  end

  // ----------------------------------------------------------------
  // Converter control outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_conv_start <= 1'b0;
    end else begin
      o_conv_start <= (phase == PH_TRACK) && (next_phase == PH_HOLD);
    end
  end

  assign o_tracking = (phase == PH_TRACK);
  assign o_holding = (phase == PH_HOLD);
  assign o_powered = (phase == PH_ARMED) || (phase == PH_TRACK) || (phase == PH_HOLD);
  assign o_track_channel = chan_active;

  // ----------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------
  conv_result_t in_res;
  conv_result_t out_res;
  logic res_valid;
  logic res_pop;

  assign in_res.channel = chan_active;
  assign in_res.code = i_result;
  assign res_pop = fall_ev && next_fall_idx == RESULT_FIRST_FALL && phase == PH_HOLD;

  result_buffer #(
    .WIDTH(RESULT_W),
    .DEPTH(BUF_DEPTH)
  ) u_result_buffer (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_flush(sel_fall),
    .i_in_valid(i_result_valid),
    .o_in_ready(o_result_ready),
    .i_in_data(in_res),
    .o_out_valid(res_valid),
    .i_out_ready(res_pop),
    .o_out_data(out_res)
  );

  // ----------------------------------------------------------------
  // Serial result output
  // ----------------------------------------------------------------
  logic [RESULT_BITS-1:0] out_shift;

  function automatic logic result_slot(input logic [4:0] idx);
    result_slot = (idx > RESULT_FIRST_FALL) && (idx <= RESULT_LAST_FALL);
  endfunction

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !sel_active) begin
      o_data_out <= 1'b0;
    end else if (fall_ev) begin
      if (res_pop) begin
        o_data_out <= res_valid ? out_res.code[RESULT_BITS-1] : 1'b0;
      end else if (result_slot(next_fall_idx)) begin
        o_data_out <= out_shift[RESULT_BITS-1];
      end else begin
        o_data_out <= 1'b0;
      end
    end
  end

  // Remaining result bits, next one on top
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !sel_active) begin
      out_shift <= '0;
    end else if (res_pop) begin
      out_shift <= res_valid ? {out_res.code[RESULT_BITS-2:0], 1'b0} : '0;
    end else if (fall_ev && result_slot(next_fall_idx)) begin
      out_shift <= {out_shift[RESULT_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_data_out_oe <= 1'b0;
    end else begin
      o_data_out_oe <= sel_active;
    end
  end
endmodule

// *** bench/adc_serial_port_sva.sv ***
// Checker of the serial port phases and pins
`timescale 1ns/100ps
module adc_serial_port_sva
  import adc_serial_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic i_frame_sel_n,
  input wire logic i_shift_clk,
  input wire logic o_data_out,
  input wire logic o_data_out_oe,
  input wire logic o_powered,
  input wire logic o_tracking,
  input wire logic o_holding,
  input wire logic [CHAN_BITS-1:0] o_track_channel,
  input wire logic o_conv_start
);
  // --------
  // Phase and pin relations
  // --------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_n);
  a_oe_follows_sel: assert property (o_data_out_oe == !$past(i_frame_sel_n, 3))
    else $error("oe timing");
  a_idle_off: assert property (i_frame_sel_n [*5] |-> !(o_powered || o_tracking || o_holding))
    else $error("active while deselected");
  a_track_zeros: assert property (o_tracking |-> !o_data_out)
    else $error("data during track");
  a_hold_after_track: assert property ($rose(o_holding) |-> $past(o_tracking))
    else $error("hold without track");
  a_start_once: assert property ($rose(o_holding) |-> o_conv_start ##1 !o_conv_start)
    else $error("start pulse");
  a_start_cause: assert property (o_conv_start |-> o_holding && !$past(o_holding))
    else $error("stray start");
  a_gap_unpowered: assert property ($fell(o_holding) |-> !o_powered)
    else $error("powered after hold");
  a_phase_powered: assert property ((o_tracking || o_holding) |-> o_powered)
    else $error("unpowered phase");
  a_phase_exclusive: assert property (!(o_tracking && o_holding))
    else $error("track and hold");
  a_chan_steady: assert property (o_holding |-> $stable(o_track_channel))
    else $error("channel moved");
  a_track_waits: assert property ($fell(i_frame_sel_n) && i_shift_clk |-> !o_tracking [*5])
    else $error("early track");
  a_track_prompt: assert property ($fell(i_frame_sel_n) && !i_shift_clk |-> ##[1:4] o_tracking)
    else $error("late track");
  c_conv: cover property (o_conv_start);
  c_hi_start: cover property ($fell(i_frame_sel_n) && i_shift_clk);
  c_abort: cover property (o_holding && $rose(i_frame_sel_n));
endmodule

bind adc_serial_port adc_serial_port_sva u_sva (
  .i_clock(i_clock),
  .i_rst_n(i_rst_n),
  .i_frame_sel_n(i_frame_sel_n),
  .i_shift_clk(i_shift_clk),
  .o_data_out(o_data_out),
  .o_data_out_oe(o_data_out_oe),
  .o_powered(o_powered),
  .o_tracking(o_tracking),
  .o_holding(o_holding),
  .o_track_channel(o_track_channel),
  .o_conv_start(o_conv_start)
);

// *** bench/host_master_model.sv ***
// Host serial master that frames conversions on the converter pins
`timescale 1ns/100ps
module host_master_model (
  input wire logic i_clock,
  input wire logic i_data_out,
  input wire logic i_data_out_oe,
  output logic o_frame_sel_n,
  output logic o_shift_clk,
  output logic o_cmd_in,
  output logic [15:0] o_word,
  output logic o_word_valid
);
  initial begin
    o_frame_sel_n = 1'h1;
    o_shift_clk = 1'h0;
    o_cmd_in = 1'h0;
    o_word = 16'h0000;
    o_word_valid = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  // --------
  // One conversion; fewer than 16 rises aborts it
  // --------
  task automatic conv(input logic [7:0] cmd, input bit hi, input bit stay, input int nrise);
    if (o_frame_sel_n) begin
      o_shift_clk <= hi;
      tick(4);
      o_frame_sel_n <= 1'h0;
      tick(hi ? 4 : 0);
    end
    o_shift_clk <= 1'h0;
    for (int k = 1; k <= nrise; k++) begin
      o_cmd_in <= cmd[(16 - k) % 8];
      tick(4);
      o_shift_clk <= 1'h1;
      tick(4);
      o_word[16 - k] <= i_data_out_oe ? i_data_out : 1'bx;
      if (k < nrise) o_shift_clk <= 1'h0;
    end
    if (nrise == 16) begin
      o_word_valid <= 1'h1;
      tick(1);
      o_word_valid <= 1'h0;
    end
    if (!stay || nrise < 16) begin
      o_frame_sel_n <= 1'h1;
      o_cmd_in <= ~o_cmd_in;
      tick(2);
      o_shift_clk <= 1'h0;
      tick(4);
    end
  endtask
endmodule

// *** bench/adc_serial_port_tb.sv ***
// Self-checking bench of the converter serial port
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_errors++; $display("CHECK FAILED %0t got %h exp %h", $time, a, e); end end
module adc_serial_port_tb
  import adc_serial_pkg::*;
;
  logic clk, rst_n, sel_n, sclk, cmd, dout, oe, pw, trk, hld, cs, rv, rr, wv, abort, fill;
  logic [CHAN_BITS-1:0] ch, xch;
  logic [RESULT_BITS-1:0] res;
  logic [15:0] word, exp_word;
  logic [15:0] q[$];
  logic [31:0] rnd;
  logic [7:0] c;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int i;
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  adc_serial_port DUT (
    .i_clock(clk), .i_rst_n(rst_n), .i_frame_sel_n(sel_n), .i_shift_clk(sclk), .i_cmd_in(cmd),
    .o_data_out(dout), .o_data_out_oe(oe), .o_powered(pw), .o_tracking(trk), .o_holding(hld),
    .o_track_channel(ch), .o_conv_start(cs), .i_result_valid(rv), .i_result(res), .o_result_ready(rr)
  );
  host_master_model host (
    .i_clock(clk), .i_data_out(dout), .i_data_out_oe(oe), .o_frame_sel_n(sel_n),
    .o_shift_clk(sclk), .o_cmd_in(cmd), .o_word(word), .o_word_valid(wv)
  );
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // --------
  // Analog side, result monitor, hang limit
  // --------
  always @(posedge clk) begin
    if (cs) begin
      `CHK(ch, xch)
      rnd = lfsr(rnd);
      res <= rnd[9:0];
      rv <= 1'h1;
      if (!abort) q.push_back({4'h0, rnd[9:0], 2'h0});
    end else if (rv && rr && !fill) begin
      rv <= 1'h0;
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wv) begin
      exp_word = q.pop_front();
      `CHK(word, exp_word)
    end
    if (cyc == 4000) begin
      n_errors++;
      end_sim();
    end
  end
  // --------
  // Main sequence
  // --------
  initial begin
    rst_n = 1'h0;
    rv = 1'h0;
    res = 10'h000;
    abort = 1'h0;
    fill = 1'h1;
    xch = CHAN_RESET;
    rnd = 32'h5CD5;
    tick(20);
    rst_n <= 1'h1;
    tick(4);
    rv <= 1'h1;
    tick(3);
    `CHK(rr, 1'h0) // buffer full refuses
    rv <= 1'h0;
    fill = 1'h0;
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      c = {rnd[7:6], i[2:0], rnd[2:0]};
      host.conv(c, i[1], !i[0], 16);
      xch = i[2:0];
    end
    abort = 1'h1;
    host.conv(8'h00, 1'h0, 1'h0, 10);
    abort = 1'h0;
    host.conv(8'h00, 1'h1, 1'h0, 16);
    tick(8);
    `CHK(q.size(), 0)
    end_sim();
  end
endmodule
